// ===== inc/dac_clamp_pkg.sv
// Overview of operation
// - channel config bit 4 enables output slewing; resets to 0.
// - range codes 0000-0011 give 0-5V (reset), 0-10V, +/-5V, +/-10V.
// - range codes 0100-0111 give 3.5-23.5mA, 0-20mA, 0-24mA, +/-24mA.
// - range codes 1000-1011 give 0-6V, 0-12V, +/-6V, +/-12V.
// - changing a channel's range reloads its code from its clear-level choice.
// - clear-level choice 0 loads zero scale, 1 loads mid scale; resets to 0.
// - data register at index 0x05 holds 16-bit code, read/write, resets to zero.
// - index 0x06 bits 0-3 pick supply converters A-D; all reset to 0.
// - converter select bits 15:4 are reserved read/write, reset zero, no function.
// - index 0x07 holds policy 11:10, pos 9:6, neg 5:2, polarity 1:0; reset zero.
// - clamp policy 00 is full tracking and is the reset state.
// - clamp policy 01 lets software write both positive and negative clamp fields.
// - policy 10 auto-learns positive clamp, ignoring software writes; 11 invalid.
// - clamp config bits 15:12 are reserved read/write, reset 0000.
package dac_clamp_pkg;

  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned APB_W    = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CHAN_SELECT = 6'h03;
  localparam logic [5:0] IDX_CHAN_CONFIG = 6'h04;
  localparam logic [5:0] IDX_CHAN_DATA   = 6'h05;
  localparam logic [5:0] IDX_CONV_SELECT = 6'h06;
  localparam logic [5:0] IDX_CONV_CLAMP  = 6'h07;

  // fields of the channel select register
  localparam int unsigned CHAN_PICK_LSB  = 5;
  localparam int unsigned CLEAR_LVL_LSB  = 9;

  localparam logic [15:0] CHAN_SELECT_RST = 16'h0000;
  localparam logic [15:0] CHAN_CONFIG_RST = 16'h0000;
  localparam logic [15:0] CHAN_DATA_RST   = 16'h0000;
  localparam logic [15:0] CONV_SELECT_RST = 16'h0000;
  localparam logic [15:0] CONV_CLAMP_RST  = 16'h0000;
  localparam logic [15:0] ZERO_SCALE      = 16'h0000;
  localparam logic [15:0] MID_SCALE       = 16'h8000;
  localparam logic [3:0]  POS_CLAMP_LOW   = 4'h0;

  // output span classes by the top two range bits
  localparam logic [1:0] RANGE_GRP_VOLT  = 2'h0;
  localparam logic [1:0] RANGE_GRP_CURR  = 2'h1;
  localparam logic [1:0] RANGE_GRP_OVER  = 2'h2;

  typedef enum logic [1:0] {
    CLAMP_TRACK   = 2'b00,
    CLAMP_MANUAL  = 2'b01,
    CLAMP_AUTO    = 2'b10,
    CLAMP_INVALID = 2'b11
  } clamp_policy_t;

  typedef struct packed {
    logic [10:0] upper;
    logic        slew_on;
    logic [3:0]  range;
  } chan_cfg_t;

  typedef struct packed {
    logic [3:0]    reserved;
    clamp_policy_t clamp_policy;
    logic [3:0]    pos_arm_clamp;
    logic [3:0]    neg_arm_clamp;
    logic [1:0]    arm_polarity_pick;
  } clamp_cfg_t;

  typedef struct packed {
    chan_cfg_t   cfg;
    logic [15:0] code;
  } chan_state_t;

  typedef struct packed {
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [15:0]          chan_select;
    logic [15:0]          conv_select;
    clamp_cfg_t [3:0]     conv_cfg;
    logic [3:0]           clamp_bad;
  } regs_state_t;

  function automatic logic range_is_voltage(input logic [3:0] r);
    return (r[3:2] == RANGE_GRP_VOLT) || (r[3:2] == RANGE_GRP_OVER);
  endfunction

  function automatic logic range_is_current(input logic [3:0] r);
    return r[3:2] == RANGE_GRP_CURR;
  endfunction

endpackage

// ===== rtl/dac_channel_slot.sv
`timescale 1ns/1ps
module dac_channel_slot (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      wr_cfg,
  input  wire logic                      wr_code,
  input  wire logic [15:0]               wdata,
  input  wire logic                      clear_level_choice,
  output dac_clamp_pkg::chan_cfg_t       cfg,
  output logic      [15:0]               code
);

  dac_clamp_pkg::chan_state_t st_reg;
  dac_clamp_pkg::chan_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_code) begin
      st_next.code = wdata;
    end
    if (wr_cfg) begin
      st_next.cfg = dac_clamp_pkg::chan_cfg_t'(wdata);
      if (wdata[3:0] != st_reg.cfg.range) begin
        st_next.code = clear_level_choice ? dac_clamp_pkg::MID_SCALE
                                          : dac_clamp_pkg::ZERO_SCALE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.cfg  <= dac_clamp_pkg::chan_cfg_t'(dac_clamp_pkg::CHAN_CONFIG_RST);
      st_reg.code <= dac_clamp_pkg::CHAN_DATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg  = st_reg.cfg;
  assign code = st_reg.code;

  property p_slew_follows_write;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg |=> cfg.slew_on == $past(wdata[4]);
  endproperty
  a_slew_follows_write: assert property (p_slew_follows_write)
    else $error("slew enable did not follow the config write");

  property p_range_follows_write;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg |=> cfg.range == $past(wdata[3:0]) && cfg.upper == $past(wdata[15:5]);
  endproperty
  a_range_follows_write: assert property (p_range_follows_write)
    else $error("range field did not follow the config write");

  property p_range_change_reloads;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && !clear_level_choice && wdata[3:0] != cfg.range
        |=> code == dac_clamp_pkg::ZERO_SCALE;
  endproperty
  a_range_change_reloads: assert property (p_range_change_reloads)
    else $error("range change did not load zero scale");

  property p_range_change_mid;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && clear_level_choice && wdata[3:0] != cfg.range
        |=> code == dac_clamp_pkg::MID_SCALE;
  endproperty
  a_range_change_mid: assert property (p_range_change_mid)
    else $error("range change did not load mid scale");

endmodule

// ===== rtl/dac_range_and_clamp_regs.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module dac_range_and_clamp_regs #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [ADDR_W-1:0]                  paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [3:0][3:0]                    learn_code,
  input  wire logic [3:0]                         learn_valid,
  output dac_clamp_pkg::chan_cfg_t [3:0]          chan_cfg,
  output logic      [3:0][15:0]                   chan_code,
  output dac_clamp_pkg::clamp_cfg_t [3:0]         conv_cfg,
  output logic      [3:0]                         conv_clamp_invalid
);

  dac_clamp_pkg::regs_state_t st_reg;
  dac_clamp_pkg::regs_state_t st_next;

  logic        setup;
  logic        access;
  logic        mapped;
  logic [5:0]  idx;
  logic [3:0]  chan_pick;
  logic [3:0]  clear_level_choice;
  logic [3:0]  conv_pick;
  logic [3:0]  wr_cfg;
  logic [3:0]  wr_code;
  logic [2:0]  first_chan;
  logic [2:0]  first_conv;

  // lowest set bit: {found, index}
  function automatic logic [2:0] first_set(input logic [3:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (s[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic dac_clamp_pkg::clamp_cfg_t clamp_write(
    input dac_clamp_pkg::clamp_cfg_t old_cfg,
    input logic [15:0]               w
  );
    dac_clamp_pkg::clamp_cfg_t n;
    dac_clamp_pkg::clamp_cfg_t r;
    n = dac_clamp_pkg::clamp_cfg_t'(w);
    r = old_cfg;
    r.reserved          = n.reserved;
    r.clamp_policy      = n.clamp_policy;
    r.arm_polarity_pick = n.arm_polarity_pick;
    case (n.clamp_policy)
      dac_clamp_pkg::CLAMP_MANUAL: begin
        r.pos_arm_clamp = n.pos_arm_clamp;
        r.neg_arm_clamp = n.neg_arm_clamp;
      end
      dac_clamp_pkg::CLAMP_AUTO: begin
        r.neg_arm_clamp = n.neg_arm_clamp;
      end
      default: begin
        r.pos_arm_clamp = old_cfg.pos_arm_clamp;
      end
    endcase
    return r;
  endfunction

  assign idx                = paddr[7:2];
  assign setup              = psel && !penable;
  assign access             = psel && penable && st_reg.pready;
  assign chan_pick          = st_reg.chan_select[dac_clamp_pkg::CHAN_PICK_LSB +: 4];
  assign clear_level_choice = st_reg.chan_select[dac_clamp_pkg::CLEAR_LVL_LSB +: 4];
  assign conv_pick          = st_reg.conv_select[3:0];
  assign first_chan         = first_set(chan_pick);
  assign first_conv         = first_set(conv_pick);
  assign mapped             = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0)
                              && idx >= dac_clamp_pkg::IDX_CHAN_SELECT
                              && idx <= dac_clamp_pkg::IDX_CONV_CLAMP;

  for (genvar g = 0; g < dac_clamp_pkg::NUM_CH; g++) begin : g_chan
    assign wr_cfg[g]  = access && pwrite && mapped && chan_pick[g]
                        && idx == dac_clamp_pkg::IDX_CHAN_CONFIG;
    assign wr_code[g] = access && pwrite && mapped && chan_pick[g]
                        && idx == dac_clamp_pkg::IDX_CHAN_DATA;

    dac_channel_slot i_dac_channel_slot (
      .pclk               (pclk),
      .presetn            (presetn),
      .wr_cfg             (wr_cfg[g]),
      .wr_code            (wr_code[g]),
      .wdata              (pwdata[15:0]),
      .clear_level_choice (clear_level_choice[g]),
      .cfg                (chan_cfg[g]),
      .code               (chan_code[g])
    );
  end

  always_comb begin
    st_next         = st_reg;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (setup) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !mapped;
      st_next.prdata  = 32'h0000_0000;
      if (mapped && !pwrite) begin
        case (idx)
          dac_clamp_pkg::IDX_CHAN_SELECT: st_next.prdata[15:0] = st_reg.chan_select;
          dac_clamp_pkg::IDX_CHAN_CONFIG: begin
            if (first_chan[2]) begin
              st_next.prdata[15:0] = chan_cfg[first_chan[1:0]];
            end
          end
          dac_clamp_pkg::IDX_CHAN_DATA: begin
            if (first_chan[2]) begin
              st_next.prdata[15:0] = chan_code[first_chan[1:0]];
            end
          end
          dac_clamp_pkg::IDX_CONV_SELECT: st_next.prdata[15:0] = st_reg.conv_select;
          dac_clamp_pkg::IDX_CONV_CLAMP: begin
            if (first_conv[2]) begin
              st_next.prdata[15:0] = st_reg.conv_cfg[first_conv[1:0]];
            end
          end
          default: st_next.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (access && pwrite && mapped) begin
      case (idx)
        dac_clamp_pkg::IDX_CHAN_SELECT: st_next.chan_select = pwdata[15:0];
        dac_clamp_pkg::IDX_CONV_SELECT: st_next.conv_select = pwdata[15:0];
        dac_clamp_pkg::IDX_CONV_CLAMP: begin
          for (int i = 0; i < 4; i++) begin
            if (conv_pick[i]) begin
              st_next.conv_cfg[i] = clamp_write(st_reg.conv_cfg[i], pwdata[15:0]);
            end
          end
        end
        default: st_next.chan_select = st_reg.chan_select;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      // the learned value loads only if the policy after a same-cycle software write is auto
      if (learn_valid[i] && st_next.conv_cfg[i].clamp_policy == dac_clamp_pkg::CLAMP_AUTO) begin
        st_next.conv_cfg[i].pos_arm_clamp = learn_code[i];
      end
      st_next.clamp_bad[i] = st_reg.conv_cfg[i].pos_arm_clamp == dac_clamp_pkg::POS_CLAMP_LOW
                             && dac_clamp_pkg::range_is_voltage(chan_cfg[i].range);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.prdata      <= 32'h0000_0000;
      st_reg.pready      <= 1'b0;
      st_reg.pslverr     <= 1'b0;
      st_reg.chan_select <= dac_clamp_pkg::CHAN_SELECT_RST;
      st_reg.conv_select <= dac_clamp_pkg::CONV_SELECT_RST;
      st_reg.conv_cfg    <= {4{dac_clamp_pkg::CONV_CLAMP_RST}};
      st_reg.clamp_bad   <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata             = st_reg.prdata;
  assign pready             = st_reg.pready;
  assign pslverr            = st_reg.pslverr;
  assign conv_cfg           = st_reg.conv_cfg;
  assign conv_clamp_invalid = st_reg.clamp_bad;

  property p_data_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CHAN_DATA && chan_pick[0]
        |=> chan_code[0] == $past(pwdata[15:0]);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data write did not reach channel A");

  property p_data_read_first;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && mapped && idx == dac_clamp_pkg::IDX_CHAN_DATA && chan_pick == 4'h6
        |=> pready && prdata[15:0] == $past(chan_code[1]);
  endproperty
  a_data_read_first: assert property (p_data_read_first)
    else $error("data read did not return the first selected channel");

  property p_conv_select_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_SELECT
        |=> st_reg.conv_select[3:0] == $past(pwdata[3:0]);
  endproperty
  a_conv_select_write: assert property (p_conv_select_write)
    else $error("converter select did not take the write");

  property p_conv_select_read;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_SELECT
        |=> prdata == {16'h0000, $past(st_reg.conv_select)};
  endproperty
  a_conv_select_read: assert property (p_conv_select_read)
    else $error("converter select read back wrong");

  property p_unselected_kept;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && idx == dac_clamp_pkg::IDX_CONV_CLAMP && !conv_pick[2] && !learn_valid[2]
        |=> $stable(conv_cfg[2]);
  endproperty
  a_unselected_kept: assert property (p_unselected_kept)
    else $error("unselected converter changed on clamp write");

  property p_policy_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_CLAMP && conv_pick[0]
        |=> conv_cfg[0].clamp_policy == $past(pwdata[11:10])
            && conv_cfg[0].arm_polarity_pick == $past(pwdata[1:0]);
  endproperty
  a_policy_write: assert property (p_policy_write)
    else $error("clamp policy or polarity not written");

  property p_track_keeps_pos;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_CLAMP && conv_pick[0]
        && pwdata[11:10] == 2'b00 |=> $stable(conv_cfg[0].pos_arm_clamp)
                                      && $stable(conv_cfg[0].neg_arm_clamp);
  endproperty
  a_track_keeps_pos: assert property (p_track_keeps_pos)
    else $error("tracking write changed clamp fields");

  property p_manual_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_CLAMP && conv_pick[0]
        && pwdata[11:10] == 2'b01
        |=> conv_cfg[0].pos_arm_clamp == $past(pwdata[9:6])
            && conv_cfg[0].neg_arm_clamp == $past(pwdata[5:2]);
  endproperty
  a_manual_write: assert property (p_manual_write)
    else $error("manual clamp write not applied");

  property p_auto_learn;
    @(posedge pclk) disable iff (!presetn)
      conv_cfg[0].clamp_policy == dac_clamp_pkg::CLAMP_AUTO && learn_valid[0]
        && !(access && pwrite) |=> conv_cfg[0].pos_arm_clamp == $past(learn_code[0]);
  endproperty
  a_auto_learn: assert property (p_auto_learn)
    else $error("learned clamp not loaded");

  property p_invalid_flag;
    @(posedge pclk) disable iff (!presetn)
      presetn && conv_cfg[0].pos_arm_clamp == 4'h0 && chan_cfg[0].range[3:2] == 2'b00
        |=> conv_clamp_invalid[0];
  endproperty
  a_invalid_flag: assert property (p_invalid_flag)
    else $error("invalid voltage-mode clamp not flagged");

  property p_clamp_reserved;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_CLAMP && conv_pick[3]
        |=> conv_cfg[3].reserved == $past(pwdata[15:12]);
  endproperty
  a_clamp_reserved: assert property (p_clamp_reserved)
    else $error("clamp reserved bits not stored");

  property p_refused_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && !mapped
        |=> $stable(st_reg.chan_select) && $stable(st_reg.conv_select) && $stable(chan_code);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("refused write changed a register");

  property p_ready_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready && pslverr == !$past(mapped) ##1 !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle)
    else $error("ready or error flag wrong after setup");

  property p_select_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CHAN_SELECT
        |=> st_reg.chan_select == $past(pwdata[15:0]);
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("channel select did not take the write");

  property p_select_reserved;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && mapped && idx == dac_clamp_pkg::IDX_CONV_SELECT
        |=> st_reg.conv_select[15:4] == $past(pwdata[15:4]);
  endproperty
  a_select_reserved: assert property (p_select_reserved)
    else $error("converter select reserved bits not stored");

  property p_valid_clamp;
    @(posedge pclk) disable iff (!presetn)
      presetn && (conv_cfg[0].pos_arm_clamp != 4'h0 || chan_cfg[0].range[3:2] == 2'b01)
        |=> !conv_clamp_invalid[0];
  endproperty
  a_valid_clamp: assert property (p_valid_clamp)
    else $error("clamp flagged invalid in a valid setting");

endmodule

// ===== test/dac_range_and_clamp_regs_tb.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module dac_range_and_clamp_regs_tb;
  localparam logic [7:0] A_CSEL = {dac_clamp_pkg::IDX_CHAN_SELECT, 2'b00};
  localparam logic [7:0] A_CCFG = {dac_clamp_pkg::IDX_CHAN_CONFIG, 2'b00};
  localparam logic [7:0] A_DATA = {dac_clamp_pkg::IDX_CHAN_DATA, 2'b00};
  localparam logic [7:0] A_VSEL = {dac_clamp_pkg::IDX_CONV_SELECT, 2'b00};
  localparam logic [7:0] A_VCLP = {dac_clamp_pkg::IDX_CONV_CLAMP, 2'b00};

  logic                                 pclk;
  logic                                 presetn;
  logic                                 psel;
  logic                                 penable;
  logic                                 pwrite;
  logic [7:0]                           paddr;
  logic [31:0]                          pwdata;
  logic [31:0]                          prdata;
  logic                                 pready;
  logic                                 pslverr;
  logic [3:0][3:0]                      learn_code;
  logic [3:0]                           learn_valid;
  dac_clamp_pkg::chan_cfg_t [3:0]       chan_cfg;
  logic [3:0][15:0]                     chan_code;
  dac_clamp_pkg::clamp_cfg_t [3:0]      conv_cfg;
  logic [3:0]                           conv_clamp_invalid;
  int                                   errors;
  int                                   tests_run;
  int                                   cycles;
  logic [15:0]                          ea;

  dac_range_and_clamp_regs #(.ADDR_W(8)) i_dac_range_and_clamp_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .learn_code(learn_code), .learn_valid(learn_valid), .chan_cfg(chan_cfg),
    .chan_code(chan_code), .conv_cfg(conv_cfg), .conv_clamp_invalid(conv_clamp_invalid)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic err = 1'b0);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, q, e);
    `CHECK("write error flag", err, e)
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic err = 1'b0);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHECK("read data", {16'h0000, exp}, q)
    `CHECK("read error flag", err, e)
  endtask

  // register outputs lag their cause by one edge, conv_clamp_invalid by two
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, errors);
  endtask

  function automatic logic [15:0] cv(input logic [3:0] rs, input logic [1:0] pl,
                                     input logic [3:0] ps, input logic [3:0] ng,
                                     input logic [1:0] ar);
    return {rs, pl, ps, ng, ar};
  endfunction

  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    learn_code = '0;
    learn_valid = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    for (int i = 0; i < 4; i++) begin
      `CHECK("chan_cfg reset", 16'h0000, chan_cfg[i])
      `CHECK("chan_code reset", 16'h0000, chan_code[i])
      `CHECK("conv_cfg reset", 16'h0000, conv_cfg[i])
    end
    `CHECK("pready reset", 1'b0, pready)
    for (int i = 3; i < 8; i++) rd(8'(i * 4), 16'h0000);
    end_test("reset");

    rd(8'h00, 16'h0000, 1'b1);
    rd(8'h0D, 16'h0000, 1'b1);
    wr(8'h20, 16'hFFFF, 1'b1);
    rd(A_VSEL, 16'h0000);
    end_test("unmapped");

    wr(A_VSEL, 16'hFFF5);
    rd(A_VSEL, 16'hFFF5);
    ea = cv(4'hF, 2'b01, 4'h5, 4'h3, 2'h2);
    wr(A_VCLP, ea);
    settle();
    `CHECK("conv A manual", ea, conv_cfg[0])
    `CHECK("conv C manual", ea, conv_cfg[2])
    `CHECK("conv B unpicked", 16'h0000, conv_cfg[1])
    `CHECK("pready dropped", 1'b0, pready)
    rd(A_VCLP, ea);
    wr(A_VCLP, cv(4'h0, 2'b00, 4'h7, 4'h7, 2'h1));
    settle();
    `CHECK("conv A track", cv(4'h0, 2'b00, 4'h5, 4'h3, 2'h1), conv_cfg[0])
    wr(A_VCLP, cv(4'h0, 2'b10, 4'h7, 4'h6, 2'h0));
    settle();
    `CHECK("conv A auto", cv(4'h0, 2'b10, 4'h5, 4'h6, 2'h0), conv_cfg[0])
    @(posedge pclk);
    learn_valid <= 4'b0111;
    learn_code <= {4'h0, 4'h4, 4'h1, 4'h9};
    @(posedge pclk);
    learn_valid <= 4'b0000;
    settle();
    `CHECK("conv A learned", cv(4'h0, 2'b10, 4'h9, 4'h6, 2'h0), conv_cfg[0])
    `CHECK("conv C learned", cv(4'h0, 2'b10, 4'h4, 4'h6, 2'h0), conv_cfg[2])
    `CHECK("conv B not learning", 16'h0000, conv_cfg[1])
    wr(A_VCLP, cv(4'h0, 2'b11, 4'h2, 4'h2, 2'h3));
    settle();
    `CHECK("conv A invalid policy", cv(4'h0, 2'b11, 4'h9, 4'h6, 2'h3), conv_cfg[0])
    ea = cv(4'h0, 2'b01, 4'h0, 4'h1, 2'h0);
    wr(A_VCLP, ea);
    settle();
    `CHECK("conv A pos zero", ea, conv_cfg[0])
    wr(A_VSEL, 16'h0008);
    ea = cv(4'hA, 2'b01, 4'h3, 4'h2, 2'h1);
    wr(A_VCLP, ea);
    settle();
    `CHECK("conv D manual", ea, conv_cfg[3])
    `CHECK("conv C unpicked", cv(4'h0, 2'b01, 4'h0, 4'h1, 2'h0), conv_cfg[2])
    rd(A_VCLP, ea);
    end_test("clamp");

    wr(A_CSEL, 16'h0460);
    wr(A_DATA, 16'h1234);
    settle();
    `CHECK("code A", 16'h1234, chan_code[0])
    `CHECK("code B", 16'h1234, chan_code[1])
    `CHECK("code C unpicked", 16'h0000, chan_code[2])
    rd(A_DATA, 16'h1234);
    wr(A_CCFG, 16'h0015);
    settle();
    `CHECK("cfg A slew", 1'b1, chan_cfg[0].slew_on)
    `CHECK("code A zero scale", dac_clamp_pkg::ZERO_SCALE, chan_code[0])
    `CHECK("code B mid scale", dac_clamp_pkg::MID_SCALE, chan_code[1])
    wr(A_CSEL, 16'h04C0);
    rd(A_DATA, dac_clamp_pkg::MID_SCALE);
    wr(A_CSEL, 16'h0460);
    wr(A_DATA, 16'h4321);
    wr(A_CCFG, 16'h0015);
    wr(8'h15, 16'h0BAD, 1'b1);
    settle();
    `CHECK("code A same range", 16'h4321, chan_code[0])
    end_test("channel");

    wr(A_CSEL, 16'h0020);
    for (int r = 0; r < 12; r++) begin
      wr(A_DATA, 16'hABCD);
      wr(A_CCFG, 16'(r));
      settle();
      rd(A_CCFG, 16'(r));
      `CHECK("code A after range", dac_clamp_pkg::ZERO_SCALE, chan_code[0])
      `CHECK("clamp invalid", (r / 4) != 1, conv_clamp_invalid[0])
      `CHECK("cfg B untouched", 16'h0015, chan_cfg[1])
    end
    end_test("ranges");
    print_verdict();
  end
endmodule
